// ### core/sga_consts.vh
/*
  Constants for the status, identifier and advertisement register slice.
  Assumes inclusion by bare name from files under core/.
*/
`ifndef SGA_CONSTS_VH
`define SGA_CONSTS_VH

`define SGA_REG_CONTROL     5'h00
`define SGA_REG_STATUS      5'h01
`define SGA_REG_ID_HIGH     5'h02
`define SGA_REG_ID_LOW      5'h03
`define SGA_REG_ADVERT      5'h04

`define SGA_CTRL_AN_EN_BIT  12
`define SGA_AN_EN_RESET     1'b1

`define SGA_ST_EXT_STATUS   8
`define SGA_ST_UNIDIR       7
`define SGA_ST_NO_PREAMBLE  6
`define SGA_ST_AN_DONE      5
`define SGA_ST_REM_FAULT    4
`define SGA_ST_AN_ABLE      3
`define SGA_ST_LINK         2

`define SGA_ADVERT_RESET    16'h0001

`define SGA_LINK_TIMER_US   1600
`define SGA_CLK_MHZ         10
`endif

// ### core/sga_link_hold.v
/*
  Link status qualifier: holds the live link high through a loss of sync
  until sync stays lost for a whole link timer period.
  Assumes all inputs are synchronous to core_clk.
*/
`default_nettype none

module sga_link_hold #(
  parameter TIMER_CYCLES = 16000,
  parameter CNT_W        = 14
) (
  input  wire core_clk,
  input  wire rst,
  input  wire sync_ok,
  input  wire an_enable,
  input  wire an_complete,
  input  wire xcvr_reset_done,
  output reg  link_live
);

  reg [CNT_W-1:0] lost_count;
  wire            qual_ok;
  wire            timer_full;

  assign qual_ok    = (an_complete | ~an_enable) & xcvr_reset_done;
  assign timer_full = (lost_count == TIMER_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});

  always @(posedge core_clk) begin
    if (rst) begin
      lost_count <= {CNT_W{1'b0}};
      link_live  <= 1'b0;
    end else if (sync_ok) begin
      lost_count <= {CNT_W{1'b0}};
      link_live  <= qual_ok;
    end else if (!qual_ok) begin
      lost_count <= {CNT_W{1'b0}};
      link_live  <= 1'b0;
    end else if (link_live) begin
      // Sync loss only drops the link after a full timer period
      if (timer_full) begin
        link_live  <= 1'b0;
        lost_count <= {CNT_W{1'b0}};
      end else begin
        lost_count <= lost_count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// ### core/sga_status_regs.v
/*
  Management register slice: status, identifier and MAC-mode advertisement
  registers, plus the auto-negotiation enable bit of the control register.
  Assumes a management frame engine outside presents a register address,
  a one-cycle read strobe at the end of a completed read and a one-cycle
  write strobe, all synchronous to core_clk.
*/
// Operation
// - Status bits fifteen to nine read zero
// - Status bit eight always reads one
// - Unidirectional bit reads one, writes ignored
// - Preamble-free frames bit always reads one
// - Negotiation complete bit follows completion while enabled, resets zero
// - Remote fault sticks until read clears it
// - Negotiation ability bit always reads one
// - Link bit latches low, reloads on read
// - Live link needs sync, transceiver ready, negotiation only if enabled
// - Link held through sync loss one timer
// - Identifier splits organization code, model, revision
// - Advertisement read-only, defaults to bit zero
// - Advertisement also loadable from configuration port
// - Negotiation enable from control bit twelve
`default_nettype none
`include "sga_consts.vh"

module sga_status_regs #(
  parameter [21:0] ORGANIZATION_ID = 22'h2A5A5A, // Arbitrary value
  parameter [5:0]  MODEL_NUMBER    = 6'h15,      // Arbitrary value
  parameter [3:0]  REVISION        = 4'h3,       // Arbitrary value
  parameter        LINK_TIMER_CYC  = `SGA_LINK_TIMER_US * `SGA_CLK_MHZ,
  parameter        TIMER_W         = 15
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [4:0]  reg_addr,
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  input  wire        sync_ok,
  input  wire        an_complete,
  input  wire        remote_fault,
  input  wire        xcvr_reset_done,
  input  wire        advert_cfg_valid,
  input  wire [15:0] advert_cfg,
  output reg         an_enable,
  output reg  [15:0] advert_word
);

  reg         fault_flag;
  reg         link_latch;
  wire        link_live;
  reg  [15:0] status_word;
  reg  [15:0] next_rdata;
  wire        rd_status;
  wire        wr_control;

  assign rd_status  = reg_rd && (reg_addr == `SGA_REG_STATUS);
  assign wr_control = reg_wr && (reg_addr == `SGA_REG_CONTROL);

  sga_link_hold #(
    .TIMER_CYCLES (LINK_TIMER_CYC),
    .CNT_W        (TIMER_W)
  ) u_link_hold (
    .core_clk        (core_clk),
    .rst             (rst),
    .sync_ok         (sync_ok),
    .an_enable       (an_enable),
    .an_complete     (an_complete),
    .xcvr_reset_done (xcvr_reset_done),
    .link_live       (link_live)
  );

  // Only the enable bit of the control register lives here
  always @(posedge core_clk) begin
    if (rst) begin
      an_enable <= `SGA_AN_EN_RESET;
    end else if (wr_control) begin
      an_enable <= reg_wdata[`SGA_CTRL_AN_EN_BIT];
    end
  end

  // Config port is the only writer; management writes fall through
  always @(posedge core_clk) begin
    if (rst) begin
      advert_word <= `SGA_ADVERT_RESET;
    end else if (advert_cfg_valid) begin
      advert_word <= advert_cfg;
    end
  end

  // Event wins over the read that clears it, so no fault is lost
  always @(posedge core_clk) begin
    if (rst) begin
      fault_flag <= 1'b0;
    end else if (remote_fault) begin
      fault_flag <= 1'b1;
    end else if (rd_status) begin
      fault_flag <= 1'b0;
    end
  end

  // Link loss wins over the reload, so a drop during a read still shows
  always @(posedge core_clk) begin
    if (rst) begin
      link_latch <= 1'b0;
    end else if (!link_live) begin
      link_latch <= 1'b0;
    end else if (rd_status) begin
      link_latch <= link_live;
    end
  end

  always @* begin
    status_word                      = 16'h0000;
    status_word[`SGA_ST_EXT_STATUS]  = 1'b1;
    status_word[`SGA_ST_UNIDIR]      = 1'b1;
    status_word[`SGA_ST_NO_PREAMBLE] = 1'b1;
    status_word[`SGA_ST_AN_DONE]     = an_complete & an_enable;
    status_word[`SGA_ST_REM_FAULT]   = fault_flag;
    status_word[`SGA_ST_AN_ABLE]     = 1'b1;
    status_word[`SGA_ST_LINK]        = link_latch;
  end

  always @* begin
    case (reg_addr)
      `SGA_REG_CONTROL: next_rdata = {3'h0, an_enable, 12'h000};
      `SGA_REG_STATUS:  next_rdata = status_word;
      `SGA_REG_ID_HIGH: next_rdata = ORGANIZATION_ID[21:6];
      `SGA_REG_ID_LOW:  next_rdata = {ORGANIZATION_ID[5:0], MODEL_NUMBER, REVISION};
      `SGA_REG_ADVERT:  next_rdata = advert_word;
      default:          next_rdata = 16'h0000;
    endcase
  end

  // Read data is registered every cycle from the current address
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ### tb/sga_asserts.sv
/* Checker for the status register slice.
   Assumes bind onto sga_status_regs. */
`default_nettype none
module sga_asserts (
  input wire logic        core_clk, rst, reg_rd, reg_wr, remote_fault,
  input wire logic        xcvr_reset_done, advert_cfg_valid, an_enable,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata, advert_cfg, advert_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_st;
    $past(reg_addr) == 5'h01 && !$past(rst);
  endsequence
  sequence s_set;
    remote_fault && !reg_rd ##1 (reg_addr == 5'h01 && !reg_rd) [*3];
  endsequence
  sequence s_clr;
    reg_rd && reg_addr == 5'h01 && !remote_fault && !$past(remote_fault)
    ##1 (reg_addr == 5'h01 && !remote_fault) [*3];
  endsequence
  a_zero_bits: assert property (s_st |-> reg_rdata[15:9] == 7'h00 && reg_rdata[1:0] == 2'h0)
    else $error("status zero bits set");
  a_one_bits: assert property (s_st |-> reg_rdata[8:6] == 3'h7 && reg_rdata[3])
    else $error("status fixed ones clear");
  a_advert_hold: assert property (!advert_cfg_valid |=> $stable(advert_word))
    else $error("advertisement changed");
  a_advert_load: assert property (advert_cfg_valid |=> advert_word == $past(advert_cfg))
    else $error("advertisement not loaded");
  a_en_clear: assert property (reg_wr && reg_addr == 5'h00 && !reg_wdata[12] |=> !an_enable)
    else $error("enable not cleared");
  a_fault_set: assert property (s_set |-> reg_rdata[4])
    else $error("fault not shown");
  a_fault_clear: assert property (s_clr |-> !reg_rdata[4])
    else $error("fault not cleared");
  a_link_drop: assert property ((!xcvr_reset_done && reg_addr == 5'h01) [*4] |-> !reg_rdata[2])
    else $error("link high without ready");
endmodule
bind sga_status_regs sga_asserts i_sga_asserts (.*);
`default_nettype wire

// ### tb/sga_link_model.sv
/* Link-side status source for the register slice.
   Assumes the bench sets ctl at rising edges. */
`default_nettype none
module sga_link_model (
  input wire logic core_clk,
  input wire logic [4:0] ctl,
  output var logic sync_ok, an_complete, remote_fault, xcvr_reset_done, advert_cfg_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered like the sublayer's own status outputs
  // Bit order: load, reset done, negotiation done, fault, sync
  always @(posedge core_clk) begin
    {advert_cfg_valid, xcvr_reset_done, an_complete, remote_fault, sync_ok} <= ctl;
  end
endmodule
`default_nettype wire

// ### tb/test_sga_status_regs.sv
/* Bench for the status register slice.
   Assumes the slice, checker and link model compile first. */
`default_nettype none
module test_sga_status_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [21:0] OI = 22'h2A5A5A; // Arbitrary value
  localparam [15:0] BS = 16'h01C8;
  logic core_clk = 0, rst = 1, reg_rd = 0, reg_wr = 0;
  logic [4:0] reg_addr = 0, ctl = 0;
  logic [15:0] reg_wdata = 0, advert_cfg = 16'hA5C3;
  wire [15:0] reg_rdata, advert_word;
  wire sync_ok, an_complete, remote_fault, xcvr_reset_done, advert_cfg_valid, an_enable;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  sga_link_model i_sga_link_model (.*);
  sga_status_regs #(.ORGANIZATION_ID(OI), .LINK_TIMER_CYC(20)) i_sga_status_regs (.*);
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Strobe goes with the address, so the captured word predates the clear
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk) reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk) reg_rd <= 1'b0;
    @(negedge core_clk) chk(reg_rdata, exp);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk) reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic set(input logic [4:0] c);
    @(posedge core_clk) ctl <= c;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(5'h01, BS);
    rd(5'h01, BS);
    rd(5'h02, OI[21:6]);
    rd(5'h03, {OI[5:0], 6'h15, 4'h3});
    rd(5'h04, 16'h0001);
    rd(5'h00, 16'h1000);
    rd(5'h1F, 16'h0000);
    wr(5'h01, 16'hFFFF);
    wr(5'h04, 16'h1234);
    rd(5'h01, BS);
    rd(5'h04, 16'h0001);
    set(5'h0D);
    repeat (4) @(posedge core_clk);
    rd(5'h01, BS | 16'h0020);
    rd(5'h01, BS | 16'h0024);
    set(5'h0F);
    set(5'h0D);
    // Fault stays unread for a few cycles so the sticky check is reached
    repeat (3) @(posedge core_clk);
    rd(5'h01, BS | 16'h0034);
    rd(5'h01, BS | 16'h0024);
    set(5'h0C);
    rd(5'h01, BS | 16'h0024);
    // Three quarters of the way through the 20-cycle timer the link must still be held
    repeat (12) @(posedge core_clk);
    rd(5'h01, BS | 16'h0024);
    repeat (20) @(posedge core_clk);
    rd(5'h01, BS | 16'h0020);
    rd(5'h01, BS | 16'h0020);
    set(5'h09);
    wr(5'h00, 16'h0000);
    rd(5'h00, 16'h0000);
    rd(5'h01, BS);
    rd(5'h01, BS | 16'h0004);
    wr(5'h00, 16'h1000);
    // Live link and then the latch need a cycle each to fall
    repeat (2) @(posedge core_clk);
    rd(5'h01, BS);
    set(5'h10);
    set(5'h00);
    rd(5'h04, 16'hA5C3);
    test_done();
  end
endmodule
`default_nettype wire
